// >>> core/iwd_pkg.sv
// Purpose: shared constants of the independent watchdog
// Assumes: 32-bit APB register bus, one aligned word per register
// Notes:   offsets are byte addresses
package iwd_pkg;

    // ==========================================================
    // bus and register map
    localparam int          ADDR_W         = 5;
    localparam logic [4:0]  OFF_COMMAND    = 5'h00;
    localparam logic [4:0]  OFF_DIVIDER    = 5'h04;
    localparam logic [4:0]  OFF_RELOAD     = 5'h08;
    localparam logic [4:0]  OFF_STATUS     = 5'h0C;
    localparam logic [4:0]  OFF_IRQ_STATUS = 5'h10;
    localparam logic [4:0]  OFF_IRQ_CLEAR  = 5'h14;
    localparam logic [4:0]  OFF_IRQ_ENABLE = 5'h18;
    localparam logic [4:0]  OFF_COUNT      = 5'h1C;

    // ==========================================================
    // command words
    localparam logic [15:0] CMD_UNLOCK     = 16'h5555;
    localparam logic [15:0] CMD_START      = 16'hCCCC;
    localparam logic [15:0] CMD_RELOAD     = 16'hAAAA;

    // ==========================================================
    // field positions and reset values
    localparam int          DIV_CODE_W     = 3;
    localparam int          STAT_DIV_BIT   = 0;
    localparam int          STAT_REL_BIT   = 1;
    localparam int          IRQ_W          = 3;
    localparam int          IRQ_TIMEOUT    = 0;
    localparam int          IRQ_DIV_DONE   = 1;
    localparam int          IRQ_REL_DONE   = 2;
    localparam logic [2:0]  RST_DIV_CODE   = 3'h0;
    localparam logic [11:0] RST_RELOAD     = 12'hFFF;
    localparam logic [2:0]  DIV_CODE_MAX   = 3'h6;
    localparam int          DIV_MIN        = 4;

    // ==========================================================
    // timing counts, in oscillator edges and clock cycles
    localparam logic [1:0]  UPD_LAST       = 2'h1;
    localparam logic [1:0]  STRAP_WAIT     = 2'h3;

endpackage : iwd_pkg

// >>> core/iwd_sync.sv
// Purpose: two-flop synchroniser for a group of pin levels
// Assumes: inputs are slow levels from outside the clock domain
// Notes:   only the second flop is visible outside
`timescale 1ns/1ps
`default_nettype none
module iwd_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock_i,
    input  wire logic             resetn_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    if (WIDTH < 1) begin : g_check
        $error("iwd_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;

endmodule : iwd_sync
`default_nettype wire

// >>> core/iwd_watchdog.sv
// Purpose: independent watchdog, prescaler plus down counter, APB slave
// Assumes: oscillator and debug levels arrive as pins, sampled on clock_i
// Notes:   system reset output is sticky until resetn_i
`timescale 1ns/1ps
`default_nettype none
module iwd_watchdog
    import iwd_pkg::*;
#(
    parameter int COUNT_W = 12,
    parameter int PRE_W   = 8
) (
    input  wire logic              clock_i,
    input  wire logic              resetn_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic                   pready_o,
    output logic      [31:0]       prdata_o,
    output logic                   pslverr_o,
    input  wire logic              low_speed_internal_osc_i,
    input  wire logic              debug_freeze_input_i,
    input  wire logic              cpu_halted_i,
    input  wire logic              hw_autostart_i,
    output logic                   sys_reset_o,
    output logic                   irq_o
);

    // ==========================================================
    // elaboration checks
    if (PRE_W < 8 || COUNT_W < 1 || COUNT_W > 12) begin : g_check
        $error("iwd_watchdog: PRE_W must be >= 8 and COUNT_W in 1..12");
    end

    // ==========================================================
    // state
    typedef struct packed {
        logic                  locked;
        logic                  running;
        logic                  fired;
        logic [DIV_CODE_W-1:0] div_shadow;
        logic [DIV_CODE_W-1:0] div_active;
        logic [COUNT_W-1:0]    rel_shadow;
        logic [COUNT_W-1:0]    rel_active;
        logic                  div_busy;
        logic                  rel_busy;
        logic [1:0]            div_upd;
        logic [1:0]            rel_upd;
        logic [PRE_W-1:0]      pre_cnt;
        logic [COUNT_W-1:0]    cnt;
        logic [IRQ_W-1:0]      irq_stat;
        logic [IRQ_W-1:0]      irq_en;
        logic [31:0]           rdata;
        logic                  osc_prev;
        logic [1:0]            strap_wait;
        logic                  strap_done;
    } iwd_state_s;

    localparam iwd_state_s STATE_RESET = '{
        locked:     1'b1,
        div_shadow: RST_DIV_CODE,
        div_active: RST_DIV_CODE,
        rel_shadow: COUNT_W'(RST_RELOAD),
        rel_active: COUNT_W'(RST_RELOAD),
        default:    '0
    };

    iwd_state_s state_reg;
    iwd_state_s state_next;

    // ==========================================================
    // pin synchronisers
    logic [3:0] pins_sync;

    iwd_sync #(
        .WIDTH (4)
    ) u_sync (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .async_i  ({hw_autostart_i, cpu_halted_i, debug_freeze_input_i, low_speed_internal_osc_i}),
        .sync_o   (pins_sync)
    );

    logic osc_rise;
    logic frozen;
    logic autostart;

    assign osc_rise  = pins_sync[0] & ~state_reg.osc_prev;
    assign frozen    = pins_sync[1] & pins_sync[2];
    assign autostart = pins_sync[3];

    // ==========================================================
    // bus decode
    logic              setup;
    logic              access;
    logic              hit;
    logic              wr;
    logic [15:0]       cmd;
    logic [DIV_CODE_W-1:0] code_sat;
    logic [PRE_W-1:0]  pre_limit;
    logic              tick;

    assign setup  = psel_i & ~penable_i;
    assign access = psel_i & penable_i;
    assign hit    = (paddr_i[1:0] == 2'b00);
    assign wr     = access & pwrite_i & hit;
    assign cmd    = pwdata_i[15:0];

    // codes above the last doubling step saturate at divide by 256
    assign code_sat  = (state_reg.div_active > DIV_CODE_MAX) ? DIV_CODE_MAX : state_reg.div_active;
    assign pre_limit = PRE_W'((32'(DIV_MIN) << code_sat) - 32'd1);
    assign tick      = osc_rise & state_reg.running & ~frozen & (state_reg.pre_cnt == pre_limit);

    // ==========================================================
    // next state
    always_comb begin
        state_next          = state_reg;
        state_next.osc_prev = pins_sync[0];

        // clear first so a same-cycle event wins
        if (wr && paddr_i == OFF_IRQ_CLEAR) begin
            state_next.irq_stat = state_reg.irq_stat & ~pwdata_i[IRQ_W-1:0];
        end

        // option strap caught once the synchroniser has settled
        if (!state_reg.strap_done) begin
            state_next.strap_wait = state_reg.strap_wait + 2'h1;
            if (state_reg.strap_wait == STRAP_WAIT) begin
                state_next.strap_done = 1'b1;
                if (autostart) begin
                    state_next.running = 1'b1;
                    state_next.cnt     = state_reg.rel_active;
                    state_next.pre_cnt = '0;
                end
            end
        end

        // updates reach the counter logic after oscillator edges
        if (osc_rise && state_reg.div_busy) begin
            if (state_reg.div_upd == UPD_LAST) begin
                state_next.div_busy               = 1'b0;
                state_next.div_active             = state_reg.div_shadow;
                state_next.irq_stat[IRQ_DIV_DONE] = 1'b1;
            end else begin
                state_next.div_upd = state_reg.div_upd + 2'h1;
            end
        end
        if (osc_rise && state_reg.rel_busy) begin
            if (state_reg.rel_upd == UPD_LAST) begin
                state_next.rel_busy               = 1'b0;
                state_next.rel_active             = state_reg.rel_shadow;
                state_next.irq_stat[IRQ_REL_DONE] = 1'b1;
            end else begin
                state_next.rel_upd = state_reg.rel_upd + 2'h1;
            end
        end

        // prescaler and down counter
        if (osc_rise && state_reg.running && !frozen) begin
            if (state_reg.pre_cnt == pre_limit) begin
                state_next.pre_cnt = '0;
                if (state_reg.cnt == '0) begin
                    state_next.fired                 = 1'b1;
                    state_next.irq_stat[IRQ_TIMEOUT] = 1'b1;
                end else begin
                    state_next.cnt = state_reg.cnt - COUNT_W'(1);
                end
            end else begin
                state_next.pre_cnt = state_reg.pre_cnt + PRE_W'(1);
            end
        end

        // a new division starts from a clean prescaler phase
        if (osc_rise && state_reg.div_busy && state_reg.div_upd == UPD_LAST) begin
            state_next.pre_cnt = '0;
        end

        // register writes
        if (wr) begin
            if (paddr_i == OFF_COMMAND) begin
                state_next.locked = (cmd != CMD_UNLOCK);
                if (cmd == CMD_START) begin
                    state_next.running = 1'b1;
                    state_next.cnt     = state_reg.rel_active;
                    if (!state_reg.running) begin
                        state_next.pre_cnt = '0;
                    end
                end else if (cmd == CMD_RELOAD) begin
                    state_next.cnt = state_reg.rel_active;
                end
            end else if (paddr_i == OFF_DIVIDER) begin
                if (!state_reg.locked) begin
                    state_next.div_shadow = pwdata_i[DIV_CODE_W-1:0];
                    state_next.div_busy   = 1'b1;
                    state_next.div_upd    = '0;
                end
            end else if (paddr_i == OFF_RELOAD) begin
                if (!state_reg.locked) begin
                    state_next.rel_shadow = pwdata_i[COUNT_W-1:0];
                    state_next.rel_busy   = 1'b1;
                    state_next.rel_upd    = '0;
                end
            end else if (paddr_i == OFF_IRQ_ENABLE) begin
                state_next.irq_en = pwdata_i[IRQ_W-1:0];
            end
        end

        // read data captured in the setup cycle
        if (setup && !pwrite_i) begin
            state_next.rdata = '0;
            if (paddr_i == OFF_DIVIDER) begin
                if (!state_reg.div_busy) begin
                    state_next.rdata[DIV_CODE_W-1:0] = state_reg.div_shadow;
                end
            end else if (paddr_i == OFF_RELOAD) begin
                if (!state_reg.rel_busy) begin
                    state_next.rdata[COUNT_W-1:0] = state_reg.rel_shadow;
                end
            end else if (paddr_i == OFF_STATUS) begin
                state_next.rdata[STAT_DIV_BIT] = state_reg.div_busy;
                state_next.rdata[STAT_REL_BIT] = state_reg.rel_busy;
            end else if (paddr_i == OFF_IRQ_STATUS) begin
                state_next.rdata[IRQ_W-1:0] = state_reg.irq_stat;
            end else if (paddr_i == OFF_IRQ_ENABLE) begin
                state_next.rdata[IRQ_W-1:0] = state_reg.irq_en;
            end else if (paddr_i == OFF_COUNT) begin
                state_next.rdata[COUNT_W-1:0] = state_reg.cnt;
            end
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // outputs
    assign pready_o    = 1'b1;
    assign pslverr_o   = access & ~hit;
    assign prdata_o    = state_reg.rdata;
    assign sys_reset_o = state_reg.fired;
    assign irq_o       = |(state_reg.irq_stat & state_reg.irq_en);

    // ==========================================================
    // assertions
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    logic wr_cmd;
    assign wr_cmd = wr && paddr_i == OFF_COMMAND;

    fire_on_zero_a: assert property (
        tick && state_reg.cnt == '0 |=> sys_reset_o ##1 sys_reset_o)
        else $error("counter at zero did not raise reset");

    count_down_a: assert property (
        tick && state_reg.cnt != '0 && !wr_cmd |=> state_reg.cnt == $past(state_reg.cnt) - COUNT_W'(1))
        else $error("counter did not step down on tick");

    start_cmd_a: assert property (
        wr_cmd && cmd == CMD_START |=> state_reg.running && state_reg.cnt == $past(state_reg.rel_active))
        else $error("start command did not run the counter");

    reload_cmd_a: assert property (
        wr_cmd && cmd == CMD_RELOAD |=> state_reg.cnt == $past(state_reg.rel_active))
        else $error("reload command did not load counter");

    locked_ignore_a: assert property (
        wr && paddr_i == OFF_RELOAD && state_reg.locked |=> $stable(state_reg.rel_shadow))
        else $error("locked reload write took effect");

    relock_cmd_a: assert property (
        wr_cmd && cmd != CMD_UNLOCK |=> state_reg.locked)
        else $error("command other than unlock left registers open");

    busy_set_a: assert property (
        wr && paddr_i == OFF_RELOAD && !state_reg.locked |=> state_reg.rel_busy)
        else $error("reload busy not set by write");

    busy_done_a: assert property (
        state_reg.div_busy && state_reg.div_upd == UPD_LAST && osc_rise && !wr
        |=> !state_reg.div_busy && state_reg.div_active == $past(state_reg.div_shadow))
        else $error("divider busy not cleared after update");

    busy_read_a: assert property (
        setup && !pwrite_i && paddr_i == OFF_RELOAD && state_reg.rel_busy |=> prdata_o == 32'h0)
        else $error("reload read during update returned data");

    freeze_hold_a: assert property (
        frozen && !wr_cmd && state_reg.strap_done |=> $stable(state_reg.cnt))
        else $error("counter moved while frozen");

    divider_range_a: assert property (
        state_reg.running |-> state_reg.pre_cnt <= pre_limit
            && (state_reg.div_active != 3'h7 || pre_limit == PRE_W'(8'hFF)))
        else $error("prescaler beyond selected division");

    strap_start_a: assert property (
        !state_reg.strap_done && state_reg.strap_wait == STRAP_WAIT && autostart |=> state_reg.running)
        else $error("option strap did not start watchdog");

    div_busy_set_a: assert property (
        wr && paddr_i == OFF_DIVIDER && !state_reg.locked |=> state_reg.div_busy)
        else $error("divider busy not set by write");

    locked_divider_a: assert property (
        wr && paddr_i == OFF_DIVIDER && state_reg.locked |=> $stable(state_reg.div_shadow))
        else $error("locked divider write took effect");

    reset_sticky_a: assert property (
        sys_reset_o |=> sys_reset_o)
        else $error("system reset request dropped");

    stopped_hold_a: assert property (
        !state_reg.running && !wr_cmd && state_reg.strap_done |=> !state_reg.running && $stable(state_reg.cnt))
        else $error("stopped counter moved");

    timeout_cov: cover property (tick && state_reg.cnt == '0);
    reload_cov: cover property (wr_cmd && cmd == CMD_RELOAD && state_reg.running);
    freeze_cov: cover property (frozen && state_reg.running);
    update_cov: cover property (state_reg.rel_busy ##[1:40] !state_reg.rel_busy);
    div_update_cov: cover property (state_reg.div_busy ##[1:40] !state_reg.div_busy);

endmodule : iwd_watchdog
`default_nettype wire

// >>> verif/iwd_watchdog_test.sv
// Purpose: self-checking bench of the independent watchdog
// Assumes: zero-wait APB slave; the bench drives the oscillator pin
// Notes:   oscillator idles low between bursts so tick counts stay exact
`timescale 1ns/1ps
`default_nettype none
module iwd_watchdog_test
    import iwd_pkg::*;
;
    logic              clock;
    logic              resetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic              pready;
    logic [31:0]       prdata;
    logic              pslverr;
    logic              osc;
    logic              freeze;
    logic              halted;
    logic              autostart;
    logic              sys_reset;
    logic              irq;
    logic [31:0]       rd;
    logic              er;
    int                num_errors = 0;
    int                tests_run  = 0;

    iwd_watchdog dut_u (
        .clock_i                  (clock),
        .resetn_i                 (resetn),
        .psel_i                   (psel),
        .penable_i                (penable),
        .pwrite_i                 (pwrite),
        .paddr_i                  (paddr),
        .pwdata_i                 (pwdata),
        .pready_o                 (pready),
        .prdata_o                 (prdata),
        .pslverr_o                (pslverr),
        .low_speed_internal_osc_i (osc),
        .debug_freeze_input_i     (freeze),
        .cpu_halted_i             (halted),
        .hw_autostart_i           (autostart),
        .sys_reset_o              (sys_reset),
        .irq_o                    (irq)
    );

    // ==========================================================
    // clock and shared tasks
    always #2 clock = ~clock;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        check({31'h0, pslverr}, {31'h0, (a[1:0] != 2'h0)});
        rd      = prdata;
        er      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdchk

    // one oscillator period of 12 clocks, then the pin rests low
    task automatic pulse(input int n);
        repeat (n) begin
            osc <= 1'b1;
            repeat (6) @(posedge clock);
            osc <= 1'b0;
            repeat (6) @(posedge clock);
        end
    endtask : pulse

    task automatic fire_after(input int max, input int exp);
        int n;
        n = 0;
        while (sys_reset !== 1'b1 && n < max) begin
            pulse(1);
            n++;
        end
        check(32'(n), 32'(exp));
    endtask : fire_after

    task automatic reboot(input logic a);
        resetn    <= 1'b0;
        autostart <= a;
        psel      <= 1'b0;
        penable   <= 1'b0;
        osc       <= 1'b0;
        freeze    <= 1'b0;
        halted    <= 1'b0;
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        repeat (8) @(posedge clock);
    endtask : reboot

    task automatic setup(input logic [2:0] code, input logic [11:0] reload_field);
        wr(OFF_COMMAND, {16'h0, CMD_UNLOCK});
        wr(OFF_DIVIDER, {29'h0, code});
        wr(OFF_RELOAD, {20'h0, reload_field});
        pulse(3);
        rdchk(OFF_STATUS, 32'h0);
    endtask : setup

    // ==========================================================
    // scenarios
    task automatic t_reset_map();
        reboot(1'b0);
        rdchk(OFF_DIVIDER, 32'h0);
        rdchk(OFF_RELOAD, 32'hFFF);
        rdchk(OFF_STATUS, 32'h0);
        rdchk(OFF_IRQ_ENABLE, 32'h0);
        wr(OFF_COMMAND, 32'h0000_1234);
        rdchk(OFF_COMMAND, 32'h0);
        apb(1'b0, 5'h02, 32'h0);
        check({31'h0, er}, 32'h1);
    endtask : t_reset_map

    task automatic t_lock_busy();
        wr(OFF_RELOAD, 32'h123);
        rdchk(OFF_RELOAD, 32'hFFF);
        wr(OFF_COMMAND, {16'h0, CMD_UNLOCK});
        wr(OFF_RELOAD, 32'h123);
        rdchk(OFF_STATUS, 32'h2);
        rdchk(OFF_RELOAD, 32'h0);
        pulse(3);
        rdchk(OFF_STATUS, 32'h0);
        rdchk(OFF_RELOAD, 32'h123);
        wr(OFF_COMMAND, 32'h0000_1234);
        wr(OFF_RELOAD, 32'h456);
        pulse(3);
        rdchk(OFF_RELOAD, 32'h123);
        wr(OFF_COMMAND, {16'h0, CMD_UNLOCK});
        wr(OFF_DIVIDER, 32'h5);
        rdchk(OFF_STATUS, 32'h1);
        pulse(3);
        rdchk(OFF_STATUS, 32'h0);
        rdchk(OFF_DIVIDER, 32'h5);
        rdchk(OFF_IRQ_STATUS, 32'h6);
        wr(OFF_IRQ_ENABLE, 32'h2);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h1);
        wr(OFF_IRQ_CLEAR, 32'h6);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h0);
        rdchk(OFF_IRQ_STATUS, 32'h0);
    endtask : t_lock_busy

    task automatic t_timeout(input logic [2:0] code, input logic [11:0] reload_field);
        int div;
        div = (code == 3'h7) ? 256 : (DIV_MIN << code);
        reboot(1'b0);
        setup(code, reload_field);
        wr(OFF_COMMAND, {16'h0, CMD_START});
        fire_after(300, (int'(reload_field) + 1) * div);
        rdchk(OFF_IRQ_STATUS, 32'h7);
        pulse(3);
        check({31'h0, sys_reset}, 32'h1);
    endtask : t_timeout

    task automatic t_reload();
        reboot(1'b0);
        setup(3'h0, 12'h3);
        wr(OFF_COMMAND, {16'h0, CMD_START});
        pulse(12);
        rdchk(OFF_COUNT, 32'h0);
        wr(OFF_COMMAND, {16'h0, CMD_RELOAD});
        rdchk(OFF_COUNT, 32'h3);
        pulse(12);
        check({31'h0, sys_reset}, 32'h0);
        fire_after(40, 4);
    endtask : t_reload

    task automatic t_freeze();
        reboot(1'b0);
        setup(3'h0, 12'h3);
        halted <= 1'b1;
        freeze <= 1'b1;
        wr(OFF_COMMAND, {16'h0, CMD_START});
        pulse(40);
        check({31'h0, sys_reset}, 32'h0);
        rdchk(OFF_COUNT, 32'h3);
        freeze <= 1'b0;
        repeat (50) @(posedge clock);
        rdchk(OFF_COUNT, 32'h3);
        fire_after(40, 16);
    endtask : t_freeze

    task automatic t_autostart();
        logic [31:0] idle;
        reboot(1'b1);
        rdchk(OFF_COUNT, 32'hFFF);
        pulse(4);
        rdchk(OFF_COUNT, 32'hFFE);
        wr(OFF_COMMAND, {16'h0, CMD_RELOAD});
        rdchk(OFF_COUNT, 32'hFFF);
        reboot(1'b0);
        apb(1'b0, OFF_COUNT, 32'h0);
        idle = rd;
        pulse(8);
        rdchk(OFF_COUNT, idle);
        check({31'h0, sys_reset}, 32'h0);
    endtask : t_autostart

    // ==========================================================
    // sequence, watchdog and verdict
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (80000) @(posedge clock);
        num_errors++;
        end_of_test();
    end

    initial begin
        clock     = 1'b0;
        resetn    = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = '0;
        pwdata    = 32'h0;
        osc       = 1'b0;
        freeze    = 1'b0;
        halted    = 1'b0;
        autostart = 1'b0;
        t_reset_map();
        t_lock_busy();
        for (int c = 0; c < 8; c++) begin
            t_timeout(3'(c), 12'h0);
        end
        t_timeout(3'h0, 12'h3);
        t_timeout(3'h1, 12'h1);
        t_reload();
        t_freeze();
        t_autostart();
        end_of_test();
    end
endmodule : iwd_watchdog_test
`default_nettype wire
